// >>> hw/adc_ctrl.sv
// converter control: sleep, reset and compare trigger behaviour
// Summary of operation
// (RQ1) runs during sleep only with rc clock
// (RQ2) rc clock delays start one instruction
// (RQ3) end clears go bit, loads result
// (RQ4) enabled converter interrupt wakes sleeping core
// (RQ5) disabled interrupt: stay asleep, power bit kept
// (RQ6) non-rc sleep aborts, powers down, bit kept
// (RQ7) software sleeps right after setting go
// (RQ8) reset clears registers, aborts, pins analog
// (RQ9) result undefined at power-on, else kept
// (RQ10) compare mode 1011 with power starts conversion
// (RQ11) compare event clears sixteen bit timer
// (RQ12) powered off: event ignored, timer cleared
// (RQ13) software selects channel, waits acquisition first
// (RQ14) clearing go aborts; two-period acquisition wait
// (RQ15) conversion lasts nine and half periods
// (RQ16) clock select: 2, 8, 32 osc or rc
// (RQ17) completion always sets converter interrupt flag
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
module adc_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int RC_CYCLES = `RC_TAD_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        power_on_reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        core_asleep,
    input  wire logic        compare_event,
    input  wire logic [7:0]  sample_data,
    output logic             converter_powered,
    output logic             sample_hold,
    output logic [2:0]       input_channel_select,
    output logic [2:0]       pin_analog_config,
    output logic [7:0]       port_a_direction,
    output logic [7:0]       port_e_direction,
    output logic             wake_request,
    output logic             timer_clear,
    output logic [15:0]      sixteen_bit_timer,
    output logic             irq
);
    byte_t       main_ctrl;
    byte_t       conversion_result;
    byte_t       irq_flags;
    byte_t       irq_enables;
    byte_t       analog_cfg;
    byte_t       core_irq;
    byte_t       port_a_dir;
    byte_t       port_e_dir;
    byte_t       compare_ctrl;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    conv_state_e state;
    logic [4:0]  half_count;
    logic [1:0]  delay_count;
    logic        result_valid;
    logic        half_tick;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic        go_clear;
    logic        go_set_sw;
    logic        trigger_start;
    logic        conv_done;
    logic        conv_abort;
    logic        sleep_kill;
    logic        instr_tick;
    logic [1:0]  instr_count;
    logic [1:0]  clock_select;

    function automatic logic is_write(input logic [7:0] off);
        return ap_write && ap_addr == off;
    endfunction

    assign clock_select = main_ctrl[7:6];

    // one cycle data phase, no wait states
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end else if (hready) begin
            ap_write <= hsel && htrans[1] && hwrite;
            ap_addr  <= haddr[9:2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[9:2])
                `OFF_CONV_MAIN_CTRL:   hrdata <= {24'h0, main_ctrl};
                `OFF_CONV_RESULT:      hrdata <= {24'h0, conversion_result};
                `OFF_PERIPH_IRQ_FLAGS: hrdata <= {24'h0, irq_flags};
                `OFF_PERIPH_IRQ_EN:    hrdata <= {24'h0, irq_enables};
                `OFF_ANALOG_PIN_CFG:   hrdata <= {24'h0, analog_cfg};
                `OFF_CORE_IRQ_CTRL:    hrdata <= {24'h0, core_irq};
                `OFF_PORT_A_DIR:       hrdata <= {24'h0, port_a_dir};
                `OFF_PORT_E_DIR:       hrdata <= {24'h0, port_e_dir};
                `OFF_COMPARE_CONTROL:  hrdata <= {24'h0, compare_ctrl};
                `OFF_CORE_CONTROL:     hrdata <= {31'h0, result_valid};
                `OFF_IRQ_STATUS:       hrdata <= {29'h0, irq_status};
                `OFF_IRQ_MASK:         hrdata <= {29'h0, irq_mask};
                `OFF_TIMER_COUNT:      hrdata <= {16'h0, sixteen_bit_timer};
                default:               hrdata <= 32'h00000000;
            endcase
        end
    end

    // plain software registers; reset restores all of them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog_cfg   <= `RST_ANALOG_CFG; // RQ8
            port_a_dir   <= `RST_PORT_A_DIR; // RQ8
            port_e_dir   <= `RST_PORT_E_DIR; // RQ8
            irq_enables  <= `RST_PERIPH_EN;
            core_irq     <= `RST_CORE_IRQ;
            compare_ctrl <= 8'h00;
            irq_mask     <= 3'h0;
        end else begin
            if (is_write(`OFF_ANALOG_PIN_CFG))
                analog_cfg <= {5'h0, hwdata[2:0]};
            if (is_write(`OFF_PORT_A_DIR))
                port_a_dir <= {2'h0, hwdata[5:0]};
            if (is_write(`OFF_PORT_E_DIR))
                port_e_dir <= {4'h0, hwdata[3:0]} | (port_e_dir & 8'hf0);
            if (is_write(`OFF_PERIPH_IRQ_EN))
                irq_enables <= hwdata[7:0];
            if (is_write(`OFF_CORE_IRQ_CTRL))
                core_irq <= hwdata[7:0];
            if (is_write(`OFF_COMPARE_CONTROL))
                compare_ctrl <= {4'h0, hwdata[3:0]};
            if (is_write(`OFF_IRQ_MASK))
                irq_mask <= hwdata[2:0];
        end
    end

    assign port_a_direction  = port_a_dir;
    assign port_e_direction  = port_e_dir;
    assign pin_analog_config = analog_cfg[2:0];
    assign input_channel_select = main_ctrl[5:3];

    assign go_set_sw = is_write(`OFF_CONV_MAIN_CTRL)
        && hwdata[`BIT_GO] && hwdata[`BIT_POWER_ON];
    assign go_clear  = is_write(`OFF_CONV_MAIN_CTRL) && !hwdata[`BIT_GO];
    assign trigger_start = compare_event && main_ctrl[`BIT_POWER_ON]
        && compare_ctrl[3:0] == `CMP_MODE_TRIGGER; // RQ10 RQ12
    assign sleep_kill = core_asleep
        && clock_select != `CLKSEL_RC; // RQ1 RQ6
    assign conv_done = state == conv_run && half_tick
        && half_count == 5'(`CONV_HALF_TADS - 1); // RQ15
    assign conv_abort = (state == conv_run || state == conv_delay)
        && (go_clear || sleep_kill || !main_ctrl[`BIT_POWER_ON]);

    // converter is held off in non-rc sleep while the power bit stays set
    assign converter_powered = main_ctrl[`BIT_POWER_ON] && !sleep_kill; // RQ6
    assign sample_hold = state == conv_run;

    tad_divider #(
        .RC_CYCLES (RC_CYCLES)
    ) u_div (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .run          (state == conv_run || state == conv_wait),
        .clock_select (clock_select), // RQ16
        .half_tick    (half_tick)
    );

    // instruction cycle is four oscillator periods
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_count <= 2'h0;
        end else begin
            instr_count <= instr_count + 2'h1;
        end
    end
    assign instr_tick = instr_count == 2'(`INSTR_CYCLES - 1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= conv_idle; // RQ8
            half_count  <= 5'h00;
            delay_count <= 2'h0;
        end else begin
            unique case (state)
                conv_idle: begin
                    half_count <= 5'h00;
                    if ((go_set_sw || trigger_start) && !sleep_kill) begin
                        if (clock_select == `CLKSEL_RC) begin
                            state       <= conv_delay; // RQ2
                            delay_count <= 2'h0;
                        end else begin
                            state <= conv_run;
                        end
                    end
                end
                conv_delay: begin
                    if (conv_abort) begin
                        state <= conv_idle;
                    end else if (instr_tick) begin
                        state <= conv_run; // RQ2
                    end
                end
                conv_run: begin
                    if (conv_abort) begin
                        state      <= conv_wait; // RQ14
                        half_count <= 5'h00;
                    end else if (conv_done) begin
                        state      <= conv_idle;
                        half_count <= 5'h00;
                    end else if (half_tick) begin
                        half_count <= half_count + 5'h01;
                    end
                end
                conv_wait: begin
                    // acquisition restarts after two conversion clocks
                    if (half_tick) begin
                        half_count <= half_count + 5'h01;
                    end
                    if (half_tick && half_count ==
                            5'(2 * `ABORT_WAIT_TADS - 1)) begin
                        state <= conv_idle; // RQ14
                    end
                end
            endcase
        end
    end

    // main control: go bit follows the conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_ctrl <= `RST_MAIN_CTRL; // RQ8
        end else begin
            if (is_write(`OFF_CONV_MAIN_CTRL)) begin
                main_ctrl <= {hwdata[7:3], main_ctrl[`BIT_GO] && hwdata[2],
                              1'b0, hwdata[0]};
            end
            if (go_set_sw || trigger_start) begin
                main_ctrl[`BIT_GO] <= !sleep_kill; // RQ10
            end else if (conv_done || conv_abort) begin
                main_ctrl[`BIT_GO] <= 1'b0; // RQ3 RQ14
            end
        end
    end

    // result has no reset value at power-on; other resets keep it
    always_ff @(posedge hclk) begin
        if (conv_done) begin
            conversion_result <= sample_data; // RQ3
        end else if (is_write(`OFF_CONV_RESULT)) begin
            conversion_result <= hwdata[7:0];
        end
    end

    // no async reset: a later non power-on reset must keep this flag
    always_ff @(posedge hclk) begin
        if (power_on_reset) begin
            result_valid <= 1'b0; // RQ9
        end else if (conv_done || is_write(`OFF_CONV_RESULT)) begin
            result_valid <= 1'b1;
        end
    end

    // flag set wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_flags <= `RST_PERIPH_FLAGS;
        end else begin
            if (is_write(`OFF_PERIPH_IRQ_FLAGS))
                irq_flags <= hwdata[7:0];
            if (conv_done)
                irq_flags[`BIT_CONV_IRQ] <= 1'b1; // RQ17
        end
    end

    // wake needs only the enable; global gates affect vectoring, not wake
    assign wake_request = core_asleep && irq_flags[`BIT_CONV_IRQ]
        && irq_enables[`BIT_CONV_IRQ]; // RQ4 RQ5

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status
                & ~(is_write(`OFF_IRQ_STATUS) ? hwdata[2:0] : 3'h0))
                | {conv_abort, trigger_start, conv_done};
        end
    end
    assign irq = |(irq_status & irq_mask);

    // in compare mode 1011 every compare event clears the timer, powered or not
    assign timer_clear = compare_event
        && compare_ctrl[3:0] == `CMP_MODE_TRIGGER; // RQ11 RQ12
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sixteen_bit_timer <= 16'h0000;
        end else if (timer_clear) begin
            sixteen_bit_timer <= 16'h0000; // RQ11
        end else if (instr_tick) begin
            sixteen_bit_timer <= sixteen_bit_timer + 16'h0001;
        end
    end
endmodule

// >>> hw/adc_ctrl_consts.svh
// constants for the converter control block: offsets, fields, timing
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
`define OFF_PORT_A_PINS      8'h05
`define OFF_PORT_E_PINS      8'h09
`define OFF_CORE_IRQ_CTRL    8'h0b
`define OFF_PERIPH_IRQ_FLAGS 8'h0c
`define OFF_CONV_RESULT      8'h1e
`define OFF_CONV_MAIN_CTRL   8'h1f
`define OFF_PORT_A_DIR       8'h85
`define OFF_PORT_E_DIR       8'h89
`define OFF_PERIPH_IRQ_EN    8'h8c
`define OFF_ANALOG_PIN_CFG   8'h9f
`define OFF_CORE_CONTROL     8'ha0
`define OFF_IRQ_STATUS       8'ha1
`define OFF_IRQ_MASK         8'ha2
`define OFF_COMPARE_CONTROL  8'ha3
`define OFF_TIMER_COUNT      8'ha4
`define RST_MAIN_CTRL        8'h00
`define RST_PERIPH_FLAGS     8'h00
`define RST_PERIPH_EN        8'h00
`define RST_ANALOG_CFG       8'h00
`define RST_PORT_A_DIR       8'h3f
`define RST_PORT_E_DIR       8'h07
`define RST_CORE_IRQ         8'h00
`define BIT_POWER_ON         0
`define BIT_GO               2
`define BIT_CONV_IRQ         6
`define BIT_GIE              7
`define BIT_PERIPHERAL_IRQ_GATE             6
`define CLKSEL_RC            2'b11
`define CMP_MODE_TRIGGER     4'hb
`define TOSC_NS              40
`define RC_TAD_NS            4000
`define RC_TAD_CYCLES        ((`RC_TAD_NS + `TOSC_NS - 1) / `TOSC_NS)
`define INSTR_CYCLES         4
`define CONV_HALF_TADS       19
`define ABORT_WAIT_TADS      2
`define IRQ_EVT_DONE         0
`define IRQ_EVT_TRIG         1
`define IRQ_EVT_ABORT        2
`endif

// >>> hw/adc_ctrl_pkg.sv
// types for the converter control block
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        conv_idle,
        conv_delay,
        conv_run,
        conv_wait
    } conv_state_e;
    typedef logic [7:0] byte_t;
endpackage

// >>> hw/tad_divider.sv
// conversion clock enable divider: half-period ticks of the selected clock
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
module tad_divider
    import adc_ctrl_pkg::*;
#(
    parameter int RC_CYCLES = `RC_TAD_CYCLES
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       run,
    input  wire logic [1:0] clock_select,
    output logic            half_tick
);
    logic [11:0] count;
    logic [11:0] limit;

    // half a conversion clock period, in system cycles
    always_comb begin
        unique case (clock_select)
            2'b00:   limit = 12'h001;
            2'b01:   limit = 12'h004;
            2'b10:   limit = 12'h010;
            2'b11:   limit = 12'(RC_CYCLES / 2);
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 12'h000;
        end else if (!run || half_tick) begin
            count <= 12'h000;
        end else begin
            count <= count + 12'h001;
        end
    end

    assign half_tick = run && (count == limit - 12'h001);
endmodule

// >>> testbench/adc_ctrl_chk.sv
// assertions on the converter control block ports
`timescale 1ns/1ns
module adc_ctrl_chk #(
    parameter int RC_CYCLES = 100
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic        core_asleep,
    input  wire logic        compare_event,
    input  wire logic        converter_powered,
    input  wire logic        sample_hold,
    input  wire logic        wake_request,
    input  wire logic        timer_clear,
    input  wire logic [15:0] sixteen_bit_timer
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence conv_end;
        sample_hold ##1 !sample_hold;
    endsequence
    // rc start may wait for the next instruction tick, hence the range
    sequence trig_on;
        timer_clear && converter_powered && !sample_hold && !core_asleep;
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_clear_cause: assert property (timer_clear |-> compare_event)
        else $error("timer cleared without compare event");
    chk_clear_zero: assert property (
        timer_clear |=> sixteen_bit_timer == 16'h0)
        else $error("timer not zero after clear");
    chk_timer_step: assert property (
        !timer_clear |=> sixteen_bit_timer - $past(sixteen_bit_timer) <= 16'h1)
        else $error("timer jumped without clear");
    chk_wake_asleep: assert property (wake_request |-> core_asleep)
        else $error("wake request while core awake");
    chk_sleep_abort: assert property (!converter_powered |=> !sample_hold)
        else $error("sampling while converter powered down");
    chk_asleep_kept: assert property (
        (core_asleep && converter_powered) ##0 conv_end |-> converter_powered)
        else $error("power dropped at end of sleep conversion");
    chk_event_start: assert property (trig_on |-> ##[1:8] sample_hold)
        else $error("compare event did not start conversion");
    chk_off_ignore: assert property (
        timer_clear && !converter_powered |=> !sample_hold [*4])
        else $error("event started conversion while off");
    chk_read_hold: assert property (
        !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without read");
endmodule
bind adc_ctrl adc_ctrl_chk #(.RC_CYCLES(RC_CYCLES)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_asleep(core_asleep),
    .compare_event(compare_event), .converter_powered(converter_powered),
    .sample_hold(sample_hold), .wake_request(wake_request),
    .timer_clear(timer_clear), .sixteen_bit_timer(sixteen_bit_timer));

// >>> testbench/core_model.sv
// model of the core and compare unit facing the converter control
`timescale 1ns/1ns
module core_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       sleep_cmd,
    input  wire logic       fire_cmd,
    input  wire logic [7:0] level,
    input  wire logic       sample_hold,
    input  wire logic       wake_request,
    output logic            core_asleep,
    output logic            compare_event,
    output logic [7:0]      sample_data
);
    logic sleep_seen;
    // analog level only valid while sampling, garbage otherwise
    assign sample_data = sample_hold ? level : ~level;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_seen <= 1'b0;
            core_asleep <= 1'b0;
        end else begin
            sleep_seen <= sleep_cmd;
            if (wake_request || !sleep_cmd) begin
                core_asleep <= 1'b0;
            end else if (!sleep_seen) begin
                core_asleep <= 1'b1;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            compare_event <= 1'b0;
        end else begin
            compare_event <= fire_cmd;
        end
    end
endmodule

// >>> testbench/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
module tb;
    typedef struct { logic [7:0] a, e, m; } note_s;
    localparam logic [7:0] RO[6] = '{8'h1f, 8'h0c, 8'h8c, 8'h9f, 8'h85, 8'h89};
    localparam logic [7:0] RV[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h07};
    logic        hclk, hresetn, power_on_reset, hsel, hwrite;
    logic        sleep_cmd, fire_cmd, rd_pend = 1'b0;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata;
    logic [7:0]  lvl, old, q;
    wire  [31:0] hrdata;
    wire  [15:0] sixteen_bit_timer;
    wire  [7:0]  sample_data, port_a_direction, port_e_direction;
    wire  [2:0]  pin_analog_config, input_channel_select;
    wire         hreadyout, hresp, core_asleep, compare_event, irq;
    wire         converter_powered, sample_hold, wake_request, timer_clear;
    int          n_fail, check_count, n;
    integer      seed;
    note_s       notes[$];
    note_s       mon;
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    adc_ctrl #(.RC_CYCLES(4)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .power_on_reset(power_on_reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_asleep(core_asleep),
        .compare_event(compare_event), .sample_data(sample_data),
        .converter_powered(converter_powered), .sample_hold(sample_hold),
        .input_channel_select(input_channel_select),
        .pin_analog_config(pin_analog_config),
        .port_a_direction(port_a_direction),
        .port_e_direction(port_e_direction),
        .wake_request(wake_request), .timer_clear(timer_clear),
        .sixteen_bit_timer(sixteen_bit_timer), .irq(irq));
    core_model u_core (
        .hclk(hclk), .hresetn(hresetn), .sleep_cmd(sleep_cmd),
        .fire_cmd(fire_cmd), .level(lvl), .sample_hold(sample_hold),
        .wake_request(wake_request), .core_asleep(core_asleep),
        .compare_event(compare_event), .sample_data(sample_data));
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
    endtask
    // one single transfer; the read answer is judged by the monitor
    task automatic xfer(input logic w, input logic [7:0] a, d, m);
        int k;
        if (!w) notes.push_back('{a, d, m});
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {22'h0, a, 2'b00};
        k = 0;
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 40);
        q = hrdata[7:0];
        if (k >= 40) begin
            chk("bus ready", 1, 0);
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        xfer(1'b1, a, d, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, e, m);
        xfer(1'b0, a, e, m);
    endtask
    task automatic run_len();
        n = 0;
        while (sample_hold !== 1'b1 && n < 20) begin tick(1); n++; end
        n = 0;
        while (sample_hold === 1'b1 && n < 400) begin tick(1); n++; end
    endtask
    task automatic conv(input logic [1:0] s, input int len);
        lvl <= 8'($random(seed));
        wr(`OFF_CONV_MAIN_CTRL, {s, 6'h01});
        wr(`OFF_CONV_MAIN_CTRL, {s, 6'h05});
        run_len();
        chk("run length", len, n);
        rd(`OFF_CONV_MAIN_CTRL, {s, 6'h01}, 8'hff);
        rd(`OFF_CONV_RESULT, lvl, 8'hff);
    endtask
    task automatic sleep_rc(input logic en);
        lvl <= 8'($random(seed));
        // a flag left from earlier runs would wake the core at once
        wr(`OFF_PERIPH_IRQ_FLAGS, 8'h00);
        wr(`OFF_CONV_MAIN_CTRL, 8'hc1);
        wr(`OFF_CONV_MAIN_CTRL, 8'hc5);
        sleep_cmd <= 1'b1;
        run_len();
        chk("rc run length", 38, n);
        tick(3);
        chk("core asleep", !en, core_asleep);
        chk("powered", 1, converter_powered);
        sleep_cmd <= 1'b0;
        rd(`OFF_CONV_RESULT, lvl, 8'hff);
    endtask
    task automatic fire();
        fire_cmd <= 1'b1;
        tick(1);
        fire_cmd <= 1'b0;
        tick(3);
        chk("timer cleared", 1, sixteen_bit_timer < 16'h4);
    endtask
    // compares each read answer against the oldest note
    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            mon = notes.pop_front();
            if (mon.m != 8'h00) begin
                chk($sformatf("reg %h", mon.a), {24'h0, mon.e & mon.m},
                    hrdata & {24'hffffff, mon.m});
            end
        end
        rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
    end
    initial begin
        seed = 32'h76bbe8cf;
        n_fail = 0;
        check_count = 0;
        {hresetn, hsel, hwrite, sleep_cmd, fire_cmd} = 5'b0;
        power_on_reset = 1'b1;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 32'h0;
        hwdata = 32'h0;
        lvl = 8'h00;
        tick(10);
        hresetn <= 1'b1;
        power_on_reset <= 1'b0;
        rd(`OFF_CORE_CONTROL, 8'h00, 8'h01);
        rd(8'h40, 8'h00, 8'hff);
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00, 8'hff);
        wr(`OFF_PORT_A_DIR, 8'h15);
        tick(1);
        chk("port a dir", 8'h15, port_a_direction);
        $display("test bus done");
        wr(`OFF_IRQ_MASK, 8'h01);
        for (int s = 0; s < 3; s++) conv(2'(s), 19 << (2 * s));
        rd(`OFF_PERIPH_IRQ_FLAGS, 8'h40, 8'h40);
        chk("irq", 1, irq);
        wr(`OFF_IRQ_MASK, 8'h00);
        tick(1);
        chk("irq masked", 0, irq);
        wr(`OFF_IRQ_STATUS, 8'h01);
        wr(`OFF_IRQ_MASK, 8'h01);
        tick(1);
        chk("irq cleared", 0, irq);
        $display("test conversion done");
        old = lvl;
        lvl <= ~old;
        wr(`OFF_CONV_MAIN_CTRL, 8'h45);
        tick(10);
        wr(`OFF_CONV_MAIN_CTRL, 8'h41);
        tick(1);
        chk("abort hold", 0, sample_hold);
        rd(`OFF_CONV_RESULT, old, 8'hff);
        rd(`OFF_IRQ_STATUS, 8'h04, 8'h04);
        tick(20);
        $display("test abort done");
        wr(`OFF_PERIPH_IRQ_EN, 8'h40);
        sleep_rc(1'b1);
        wr(`OFF_PERIPH_IRQ_EN, 8'h00);
        sleep_rc(1'b0);
        old = lvl;
        lvl <= ~old;
        wr(`OFF_CONV_MAIN_CTRL, 8'h01);
        wr(`OFF_CONV_MAIN_CTRL, 8'h05);
        sleep_cmd <= 1'b1;
        tick(3);
        chk("sleep power", 0, converter_powered);
        chk("sleep hold", 0, sample_hold);
        rd(`OFF_CONV_MAIN_CTRL, 8'h01, 8'h01);
        sleep_cmd <= 1'b0;
        rd(`OFF_CONV_RESULT, old, 8'hff);
        wr(`OFF_CONV_MAIN_CTRL, 8'h01);
        tick(20);
        $display("test sleep done");
        wr(`OFF_COMPARE_CONTROL, 8'h0b);
        wr(`OFF_PERIPH_IRQ_FLAGS, 8'h00);
        lvl <= 8'($random(seed));
        tick(40);
        fire();
        tick(30);
        rd(`OFF_CONV_MAIN_CTRL, 8'h01, 8'hff);
        rd(`OFF_CONV_RESULT, lvl, 8'hff);
        wr(`OFF_CONV_MAIN_CTRL, 8'h00);
        wr(`OFF_PERIPH_IRQ_FLAGS, 8'h00);
        fire();
        tick(30);
        rd(`OFF_PERIPH_IRQ_FLAGS, 8'h00, 8'h40);
        $display("test compare done");
        wr(`OFF_ANALOG_PIN_CFG, 8'h05);
        wr(`OFF_PORT_E_DIR, 8'h00);
        wr(`OFF_CONV_MAIN_CTRL, 8'hd9);
        tick(1);
        chk("channel", 3'h3, input_channel_select);
        hresetn <= 1'b0;
        tick(3);
        hresetn <= 1'b1;
        chk("port a dir", 8'h3f, port_a_direction);
        chk("port e dir", 8'h07, port_e_direction);
        chk("pin config", 3'h0, pin_analog_config);
        rd(`OFF_CONV_RESULT, lvl, 8'hff);
        rd(`OFF_CORE_CONTROL, 8'h01, 8'h01);
        for (int i = 0; i < 6; i++) rd(RO[i], RV[i], 8'hff);
        tick(2);
        $display("test reset done");
        close_out();
    end
endmodule
